// file: logic/dhi_consts.vh
// Constants shared by the display host interface: pin positions, modes, addresses and timing.
// Assumes a 100 MHz core clock and a header included by bare name from the design files.
//
// Overview of operation
// - Data/command select high writes display RAM; low sends the byte to commands.
// - I2C slave answers only 0111100 or 0111101; low bit from dc_sel pin.
// - Direction bit after the I2C address: one means read, zero means write.
// - Slave acknowledges address byte by holding SDA low through the ninth clock.
// - Control byte carries continuation bit, data/command bit, then six zeros.
// - Continuation bit zero makes every later byte a payload byte.
// - Control data/command bit zero routes next byte to commands, one to RAM.
// - Every display RAM write advances the column pointer by one.
// - Slave acknowledges every control byte of a write, and each payload byte only while the buffer has room.
// - Master ends writes with a stop; the slave then ends the transaction.
// - 6800 mode: read/write high reads RAM or status; low writes RAM or commands.
// - 6800 mode: enable is the strobe, active only while high with chip select low.
// - RAM reads are pipelined; first read is a dummy, real data follows.
// - 8080 mode: low read strobe with chip select low reads data or status.
// - 8080 mode: write strobe latches the byte; select routes it to RAM or commands.
// - Serial mode shifts data in on each rising serial clock, MSB first.
// - Serial mode samples data/command on eighth clock and transfers the byte then.
// - Display-on command enables outputs 100 ms later; display-off is sent first.
// - Parallel and serial ports accept transfers only while chip select is low.
// - Select pins 100, 110, 000, 010 choose 6800, 8080, serial and I2C.
// - Reset clears the serial shift register and zeroes the column counter.
`ifndef DHI_CONSTS_VH
`define DHI_CONSTS_VH

// ----------------------------------------
// Synchronised pin vector layout
// ----------------------------------------
`define PIN_W 15
`define P_SCL 0
`define P_SDA 1
`define P_CS 8
`define P_DC 9
`define P_RW 10
`define P_E 11
`define P_BS0 12
`define P_BS2 14

// ----------------------------------------
// Host port modes, coded {bs2, bs1, bs0}
// ----------------------------------------
`define SEL_6800 3'h4
`define SEL_8080 3'h6
`define SEL_SPI 3'h0
`define SEL_I2C 3'h2
`define MODE_NONE 3'h0
`define MODE_6800 3'h1
`define MODE_8080 3'h2
`define MODE_SPI 3'h3
`define MODE_I2C 3'h4

// ----------------------------------------
// Bytes, addresses and RAM geometry
// ----------------------------------------
`define I2C_ADDR_TOP 6'h1e
`define CMD_DISP_ON 8'haf
`define CMD_DISP_OFF 8'hae
`define COL_LAST 8'h83
`define RAM_DEPTH 1056
`define RAM_AW 11
`define BIT_LAST 4'h7
`define BIT_ACK 4'h8
`define BIT_FULL 4'h9

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_MHZ 100
`define DISP_ON_MS 100

`endif

// file: logic/dhi_fifo2.v
// Two-entry buffer with valid/ready on both sides.
// Assumes one clock and a synchronous-released active-low reset.
`timescale 1ns/1ps
`default_nettype none
module dhi_fifo2 #(
  parameter W = 9
) (
  input wire clk,
  input wire rst_n,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem_q [0:1];
  reg wp_q;
  reg rp_q;
  reg [1:0] cnt_q;
  wire push;
  wire pop;

  assign in_ready = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = mem_q[rp_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= 2'h0;
      mem_q[0] <= {W{1'b0}};
      mem_q[1] <= {W{1'b0}};
    end else begin
      if (push) begin
        mem_q[wp_q] <= in_data;
        wp_q <= ~wp_q;
      end
      if (pop) begin
        rp_q <= ~rp_q;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule
`default_nettype wire

// file: logic/dhi_ram.v
// Display RAM: one write port, one read port, registered read data.
// Assumes a single clock; contents are undefined after power-up.
`timescale 1ns/1ps
`default_nettype none
module dhi_ram #(
  parameter AW = 11,
  parameter DEPTH = 1056
) (
  input wire clk,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [7:0] wr_data,
  input wire rd_en,
  input wire [AW-1:0] rd_addr,
  output reg [7:0] rd_data
);
  reg [7:0] mem [0:DEPTH-1];

  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule
`default_nettype wire

// file: logic/dhi_top.v
// Host port of the display controller: 6800, 8080, serial and I2C intake, display RAM and
// command byte stream. Assumes all host pins are asynchronous to clk and the command decoder
// downstream takes bytes through cmd_valid/cmd_ready.
`timescale 1ns/1ps
`default_nettype none
`include "dhi_consts.vh"
module dhi_top #(
  parameter DISP_ON_CYCLES = `DISP_ON_MS * 1000 * `CLK_MHZ
) (
  input wire clk,
  input wire rst_n,
  input wire interface_select_0,
  input wire interface_select_1,
  input wire interface_select_2,
  input wire cs_n,
  input wire dc_sel,
  input wire rw_wr_n,
  input wire e_rd_n,
  input wire [7:0] d_in,
  output wire [7:0] d_out,
  output wire [7:0] d_oe,
  output wire cmd_valid,
  input wire cmd_ready,
  output wire [7:0] cmd_byte,
  input wire col_load,
  input wire [7:0] col_value,
  input wire [2:0] page_sel,
  output reg [7:0] column_q,
  output reg display_on_q
);
  // ----------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------
  reg [1:0] rst_sync_q;
  wire rst_core_n;
  reg [`PIN_W-1:0] s1_q;
  reg [`PIN_W-1:0] s2_q;
  reg [`PIN_W-1:0] s3_q;
  reg [`PIN_W-1:0] flt_q;
  reg [`PIN_W-1:0] prv_q;
  wire [`PIN_W-1:0] pins;
  integer i;

  assign rst_core_n = rst_sync_q[1];
  assign pins = {interface_select_2, interface_select_1, interface_select_0,
                 e_rd_n, rw_wr_n, dc_sel, cs_n, d_in};

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  // A pin level is accepted only once the second and third stages agree, which filters
  // single-sample glitches at the cost of one extra cycle of latency.
  always @(posedge clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      s1_q <= {`PIN_W{1'b1}};
      s2_q <= {`PIN_W{1'b1}};
      s3_q <= {`PIN_W{1'b1}};
      flt_q <= {`PIN_W{1'b1}};
      prv_q <= {`PIN_W{1'b1}};
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
      prv_q <= flt_q;
      for (i = 0; i < `PIN_W; i = i + 1) begin
        if (s2_q[i] == s3_q[i]) begin
          flt_q[i] <= s3_q[i];
        end
      end
    end
  end

  // ----------------------------------------
  // Mode decode and pin events
  // ----------------------------------------
  function [2:0] mode_of;
    input [2:0] sel;
    begin
      case (sel)
        `SEL_6800: mode_of = `MODE_6800;
        `SEL_8080: mode_of = `MODE_8080;
        `SEL_SPI: mode_of = `MODE_SPI;
        `SEL_I2C: mode_of = `MODE_I2C;
        default: mode_of = `MODE_NONE;
      endcase
    end
  endfunction

  function [7:0] col_inc;
    input [7:0] c;
    begin
      col_inc = (c == `COL_LAST) ? 8'h00 : c + 8'h01;
    end
  endfunction

  wire [2:0] mode;
  wire sel_n;
  wire dc;
  wire rise_scl;
  wire fall_scl;
  wire e_rise;
  wire e_fall;
  wire rd_fall;
  wire wr_rise;
  wire sda_fall;
  wire sda_rise;
  wire scl_hi;

  assign mode = mode_of(flt_q[`P_BS2:`P_BS0]);
  assign sel_n = flt_q[`P_CS];
  assign dc = flt_q[`P_DC];
  assign rise_scl = flt_q[`P_SCL] & ~prv_q[`P_SCL];
  assign fall_scl = ~flt_q[`P_SCL] & prv_q[`P_SCL];
  assign e_rise = flt_q[`P_E] & ~prv_q[`P_E];
  assign e_fall = ~flt_q[`P_E] & prv_q[`P_E];
  assign rd_fall = e_fall;
  assign wr_rise = flt_q[`P_RW] & ~prv_q[`P_RW];
  assign scl_hi = flt_q[`P_SCL] & prv_q[`P_SCL];
  assign sda_fall = scl_hi & ~flt_q[`P_SDA] & prv_q[`P_SDA];
  assign sda_rise = scl_hi & flt_q[`P_SDA] & ~prv_q[`P_SDA];

  // ----------------------------------------
  // Byte buffer towards RAM and command decoder
  // ----------------------------------------
  reg push_v;
  reg [8:0] push_w;
  wire buf_ready;
  wire out_v;
  wire out_rdy;
  wire [8:0] out_w;
  wire ram_wr;

  dhi_fifo2 #(.W(9)) u_buf (
    .clk(clk),
    .rst_n(rst_core_n),
    .in_valid(push_v),
    .in_ready(buf_ready),
    .in_data(push_w),
    .out_valid(out_v),
    .out_ready(out_rdy),
    .out_data(out_w)
  );

  assign ram_wr = out_v & out_w[8];
  assign cmd_valid = out_v & ~out_w[8];
  assign cmd_byte = out_w[7:0];
  assign out_rdy = out_w[8] | cmd_ready;

  // ----------------------------------------
  // Parallel writes and reads
  // ----------------------------------------
  wire par_wr;
  wire par_rd;
  wire rd_strobe;
  wire [7:0] status;

  // 6800 acts on the enable high pulse and takes write data as enable falls.
  assign par_wr = ~sel_n & (((mode == `MODE_6800) & e_fall & ~flt_q[`P_RW]) |
                            ((mode == `MODE_8080) & wr_rise));
  assign par_rd = ~sel_n & (((mode == `MODE_6800) & e_rise & flt_q[`P_RW]) |
                            ((mode == `MODE_8080) & rd_fall));
  assign rd_strobe = ~sel_n & (((mode == `MODE_6800) & flt_q[`P_E] & flt_q[`P_RW]) |
                               ((mode == `MODE_8080) & ~flt_q[`P_E]));
  assign status = {~buf_ready, ~display_on_q, 6'h00};

  reg [7:0] dout_q;
  reg [7:0] pre_q;
  reg fetch_q;
  wire [7:0] ram_q;
  wire rd_ram;
  wire [`RAM_AW-1:0] cur_addr;

  assign rd_ram = par_rd & dc;
  assign cur_addr = page_sel * 11'd132 + {3'h0, column_q};

  dhi_ram #(.AW(`RAM_AW), .DEPTH(`RAM_DEPTH)) u_ram (
    .clk(clk),
    .wr_en(ram_wr),
    .wr_addr(cur_addr),
    .wr_data(out_w[7:0]),
    .rd_en(rd_ram),
    .rd_addr(cur_addr),
    .rd_data(ram_q)
  );

  // The host sees the byte fetched on the previous read, so the first read after
  // a pointer move returns stale data and must be discarded.
  always @(posedge clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      dout_q <= 8'h00;
      pre_q <= 8'h00;
      fetch_q <= 1'b0;
    end else begin
      fetch_q <= rd_ram;
      if (fetch_q) begin
        pre_q <= ram_q;
      end
      if (par_rd) begin
        dout_q <= dc ? pre_q : status;
      end
    end
  end

  always @(posedge clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      column_q <= 8'h00;
    end else if (col_load) begin
      column_q <= col_value;
    end else if (ram_wr | rd_ram) begin
      column_q <= col_inc(column_q);
    end
  end

  // ----------------------------------------
  // Serial port
  // ----------------------------------------
  reg [7:0] spi_sh_q;
  reg [2:0] spi_cnt_q;
  wire spi_clk;

  assign spi_clk = (mode == `MODE_SPI) & ~sel_n & rise_scl;

  always @(posedge clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      spi_sh_q <= 8'h00;
      spi_cnt_q <= 3'h0;
    end else if (sel_n) begin
      spi_cnt_q <= 3'h0;
    end else if (spi_clk) begin
      spi_sh_q <= {spi_sh_q[6:0], flt_q[`P_SDA]};
      spi_cnt_q <= spi_cnt_q + 3'h1;
    end
  end

  // ----------------------------------------
  // I2C slave
  // ----------------------------------------
  localparam I_IDLE = 3'h0;
  localparam I_ADDR = 3'h1;
  localparam I_CTRL = 3'h2;
  localparam I_DATA = 3'h3;
  localparam I_ACK = 3'h4;
  localparam I_READ = 3'h5;

  reg [2:0] ist_q;
  reg [2:0] inext_q;
  reg [7:0] ish_q;
  reg [3:0] icnt_q;
  reg co_q;
  reg idc_q;
  reg ack_q;
  reg [7:0] tx_q;
  reg sda_low_q;
  reg i2c_push;
  wire i2c_mode;
  wire byte_done;

  assign i2c_mode = (mode == `MODE_I2C);
  assign byte_done = fall_scl & (icnt_q == `BIT_ACK);

  always @(posedge clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      ist_q <= I_IDLE;
      inext_q <= I_IDLE;
      ish_q <= 8'h00;
      icnt_q <= 4'h0;
      co_q <= 1'b0;
      idc_q <= 1'b0;
      ack_q <= 1'b0;
      tx_q <= 8'h00;
      sda_low_q <= 1'b0;
    end else if (!i2c_mode || sda_rise) begin
      ist_q <= I_IDLE;
      ack_q <= 1'b0;
      sda_low_q <= 1'b0;
    end else if (sda_fall) begin
      ist_q <= I_ADDR;
      icnt_q <= 4'h0;
      co_q <= 1'b1;
      ack_q <= 1'b0;
      sda_low_q <= 1'b0;
    end else begin
      if (rise_scl && (ist_q == I_ADDR || ist_q == I_CTRL || ist_q == I_DATA)) begin
        ish_q <= {ish_q[6:0], flt_q[`P_SDA]};
        icnt_q <= icnt_q + 4'h1;
      end
      case (ist_q)
        I_ADDR: begin
          if (byte_done) begin
            if (ish_q[7:2] == `I2C_ADDR_TOP && ish_q[1] == dc) begin
              ack_q <= 1'b1;
              sda_low_q <= 1'b1;
              ist_q <= I_ACK;
              inext_q <= ish_q[0] ? I_READ : I_CTRL;
            end else begin
              ist_q <= I_IDLE;
            end
          end
        end
        I_CTRL: begin
          if (byte_done) begin
            co_q <= ish_q[7];
            idc_q <= ish_q[6];
            ack_q <= 1'b1;
            sda_low_q <= 1'b1;
            ist_q <= I_ACK;
            inext_q <= I_DATA;
          end
        end
        I_DATA: begin
          if (byte_done) begin
            // A full buffer withholds the acknowledge so the master sees the loss.
            ack_q <= buf_ready;
            sda_low_q <= buf_ready;
            ist_q <= I_ACK;
            inext_q <= co_q ? I_CTRL : I_DATA;
          end
        end
        I_ACK: begin
          if (fall_scl) begin
            ack_q <= 1'b0;
            icnt_q <= 4'h0;
            ist_q <= inext_q;
            tx_q <= status;
            sda_low_q <= (inext_q == I_READ) & ~status[7];
          end
        end
        I_READ: begin
          if (fall_scl) begin
            if (icnt_q == `BIT_LAST) begin
              sda_low_q <= 1'b0;
              icnt_q <= `BIT_ACK;
            end else if (icnt_q == `BIT_ACK) begin
              icnt_q <= 4'h0;
              tx_q <= status;
              sda_low_q <= ~status[7];
            end else begin
              sda_low_q <= ~tx_q[6];
              tx_q <= {tx_q[6:0], 1'b0};
              icnt_q <= icnt_q + 4'h1;
            end
          end
        end
        default: begin
          ist_q <= I_IDLE;
        end
      endcase
    end
  end

  always @* begin
    i2c_push = i2c_mode & (ist_q == I_DATA) & byte_done & buf_ready;
  end

  // ----------------------------------------
  // Byte steering into the buffer
  // ----------------------------------------
  // Parallel and serial hosts cannot be stalled; a byte arriving while both entries are
  // taken is dropped and the busy status bit warns the host beforehand.
  always @* begin
    push_v = 1'b0;
    push_w = 9'h000;
    if (par_wr) begin
      push_v = 1'b1;
      push_w = {dc, flt_q[7:0]};
    end else if (spi_clk && spi_cnt_q == 3'h7) begin
      push_v = 1'b1;
      push_w = {dc, spi_sh_q[6:0], flt_q[`P_SDA]};
    end else if (i2c_push) begin
      push_v = 1'b1;
      push_w = {idc_q, ish_q};
    end
  end

  // ----------------------------------------
  // Data pins
  // ----------------------------------------
  // In I2C mode the output pin only ever pulls low, in open-drain fashion.
  assign d_out = i2c_mode ? 8'h00 : dout_q;
  assign d_oe = i2c_mode ? {5'h00, sda_low_q | ack_q, 2'h0} : {8{rd_strobe}};

  // ----------------------------------------
  // Display on/off sequencing
  // ----------------------------------------
  reg [31:0] on_cnt_q;
  reg on_wait_q;
  wire cmd_take;

  assign cmd_take = cmd_valid & cmd_ready;

  always @(posedge clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      display_on_q <= 1'b0;
      on_wait_q <= 1'b0;
      on_cnt_q <= 32'h0;
    end else if (cmd_take && cmd_byte == `CMD_DISP_OFF) begin
      display_on_q <= 1'b0;
      on_wait_q <= 1'b0;
    end else if (cmd_take && cmd_byte == `CMD_DISP_ON && !display_on_q) begin
      on_wait_q <= 1'b1;
      on_cnt_q <= 32'h0;
    end else if (on_wait_q) begin
      if (on_cnt_q == DISP_ON_CYCLES - 1) begin
        display_on_q <= 1'b1;
        on_wait_q <= 1'b0;
      end else begin
        on_cnt_q <= on_cnt_q + 32'h1;
      end
    end
  end
endmodule
`default_nettype wire

// file: sim/dhi_top_monitor.sv
// Concurrent checks on the ports of the display host interface top.
// Assumes it is bound onto dhi_top and that the host pins are filtered inside.
`timescale 1ns/1ps
`default_nettype none
module dhi_top_monitor #(
  parameter DISP_ON_CYCLES = 50
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic interface_select_0,
  input wire logic interface_select_1,
  input wire logic interface_select_2,
  input wire logic cs_n,
  input wire logic [7:0] d_oe,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic [7:0] cmd_byte,
  input wire logic col_load,
  input wire logic [7:0] column_q,
  input wire logic display_on_q
);
  // --------------------------------
  // Properties
  // --------------------------------
  localparam int LIM = DISP_ON_CYCLES + 8;
  wire logic take = cmd_valid && cmd_ready;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_reset_clear: assert property ($rose(rst_n) |-> column_q == 8'h00 && !display_on_q && !cmd_valid)
    else $error("outputs not cleared by reset");
  a_cmd_hold: assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_byte))
    else $error("command byte lost while stalled");
  a_col_step: assert property ($changed(column_q) && !$past(col_load) && !$past(col_load, 2) |->
    column_q == (($past(column_q) == 8'h83) ? 8'h00 : $past(column_q) + 8'h01))
    else $error("column pointer did not step by one");
  a_on_delay: assert property (take && cmd_byte == 8'haf && !display_on_q |=>
    !display_on_q [*8] ##[1:LIM] display_on_q)
    else $error("display on timing wrong");
  a_off_now: assert property (take && cmd_byte == 8'hae |=> !display_on_q)
    else $error("display off not immediate");
  a_oe_code: assert property (d_oe == 8'h00 || d_oe == 8'hff || d_oe == 8'h04)
    else $error("illegal drive enable pattern");
  a_par_sel: assert property (d_oe == 8'hff |-> interface_select_2 && !interface_select_0)
    else $error("bus driven outside parallel modes");
  a_i2c_sel: assert property (d_oe == 8'h04 |->
    {interface_select_2, interface_select_1, interface_select_0} == 3'b010)
    else $error("acknowledge driven outside two-wire mode");
  a_par_cs: assert property ($rose(d_oe == 8'hff) |-> !$past(cs_n, 3))
    else $error("bus driven without chip select");
  a_ack_len: assert property ($rose(d_oe == 8'h04) |-> (d_oe == 8'h04) [*4])
    else $error("acknowledge too short");
endmodule
`default_nettype wire

// file: sim/dhi_host_model.sv
// Behavioural host controller driving the parallel, serial and two-wire pins.
// Assumes the device filters its pins, so every phase lasts at least H core clocks.
`timescale 1ns/1ps
`default_nettype none
module dhi_host_model #(
  parameter H = 8
) (
  input wire logic clk,
  input wire logic [7:0] d_oe,
  input wire logic [7:0] d_out,
  output logic interface_select_0,
  output logic interface_select_1,
  output logic interface_select_2,
  output logic cs_n,
  output logic dc_sel,
  output logic rw_wr_n,
  output logic e_rd_n,
  output logic [7:0] d_in
);
  // --------------------------------
  // Pins
  // --------------------------------
  logic [7:0] dq;
  logic [2:0] sel;
  logic skip_cs;
  assign {interface_select_2, interface_select_1, interface_select_0} = sel;
  // The data line is open drain with a pull-up, so the device's pull-down wins.
  assign d_in = {dq[7:2], dq[1] & ~d_oe[2], dq[0]};
  initial begin
    sel = 3'h4;
    cs_n = 1'b1;
    dc_sel = 1'b0;
    rw_wr_n = 1'b1;
    e_rd_n = 1'b0;
    dq = 8'hff;
    skip_cs = 1'b0;
  end
  // --------------------------------
  // Transfers
  // --------------------------------
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic mode(input logic [2:0] s);
    wt(1);
    sel <= s;
    e_rd_n <= (s == 3'h6);
    rw_wr_n <= 1'b1;
    cs_n <= 1'b1;
    dc_sel <= 1'b1;
    dq <= 8'hff;
    wt(4 * H);
  endtask
  task automatic pwr(input logic dc, input logic [7:0] b);
    wt(1);
    cs_n <= skip_cs;
    dc_sel <= dc;
    dq <= b;
    rw_wr_n <= (sel == 3'h6);
    wt(H);
    if (sel == 3'h4) e_rd_n <= 1'b1;
    else rw_wr_n <= 1'b0;
    wt(H);
    if (sel == 3'h4) e_rd_n <= 1'b0;
    else rw_wr_n <= 1'b1;
    wt(H);
    cs_n <= 1'b1;
    dq <= ~b;
  endtask
  task automatic prd(input logic dc, output logic [7:0] b);
    wt(1);
    cs_n <= 1'b0;
    dc_sel <= dc;
    rw_wr_n <= 1'b1;
    dq <= ~dq;
    wt(H);
    e_rd_n <= (sel != 3'h6);
    wt(H);
    // An undriven bus reads back inverted, so a missing drive enable shows up as bad data.
    b = ~(d_out ^ d_oe);
    e_rd_n <= (sel == 3'h6);
    wt(H);
    cs_n <= 1'b1;
  endtask
  task automatic spi(input logic dc, input logic [7:0] b, input int n);
    wt(1);
    cs_n <= 1'b0;
    dc_sel <= dc;
    for (int i = 0; i < n; i++) begin
      wt(1);
      dq[0] <= 1'b0;
      dq[1] <= b[7 - i];
      wt(H);
      dq[0] <= 1'b1;
      wt(H - 1);
    end
    wt(1);
    dq[0] <= 1'b0;
    dq[1] <= ~dq[1];
  endtask
  task automatic desel;
    wt(1);
    cs_n <= 1'b1;
    wt(2 * H);
  endtask
  task automatic i2c_start;
    wt(1);
    dq[1:0] <= 2'h3;
    wt(H);
    dq[1] <= 1'b0;
    wt(H);
    dq[0] <= 1'b0;
    wt(H);
  endtask
  task automatic i2c_stop;
    wt(1);
    dq[1] <= 1'b0;
    wt(H);
    dq[0] <= 1'b1;
    wt(H);
    dq[1] <= 1'b1;
    wt(H);
  endtask
  task automatic i2c_byte(input logic [7:0] b, output logic ack);
    for (int i = 0; i < 9; i++) begin
      wt(2);
      dq[1] <= (i < 8) ? b[7 - i] : 1'b1;
      wt(H - 2);
      dq[0] <= 1'b1;
      wt(H / 2);
      ack = d_in[1];
      wt(H / 2);
      dq[0] <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// file: sim/tb_dhi_top.sv
// Self-checking bench for the display host interface top.
// Assumes the host model drives all host pins and the bench plays the command decoder.
`timescale 1ns/1ps
`default_nettype none
module tb_dhi_top;
  localparam int DISP_ON_CYCLES = 50;
  logic clk, rst_n, cmd_ready, col_load, stall, ack;
  logic interface_select_0, interface_select_1, interface_select_2;
  logic cs_n, dc_sel, rw_wr_n, e_rd_n, cmd_valid, display_on_q;
  logic [7:0] d_in, d_out, d_oe, cmd_byte, col_value, column_q, rb, d0, d1, cv;
  logic [2:0] page_sel;
  logic [7:0] seq [9];
  integer seed = 32'h5d24c6c8;
  int err_count = 0;
  int n_checks = 0;
  logic [7:0] exp_q [$];
  // --------------------------------
  // Harness
  // --------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  dhi_top #(.DISP_ON_CYCLES(DISP_ON_CYCLES)) dhi_top_i (.clk(clk), .rst_n(rst_n),
    .interface_select_0(interface_select_0), .interface_select_1(interface_select_1),
    .interface_select_2(interface_select_2), .cs_n(cs_n), .dc_sel(dc_sel), .rw_wr_n(rw_wr_n),
    .e_rd_n(e_rd_n), .d_in(d_in), .d_out(d_out), .d_oe(d_oe), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_byte(cmd_byte), .col_load(col_load), .col_value(col_value),
    .page_sel(page_sel), .column_q(column_q), .display_on_q(display_on_q));
  dhi_host_model dhi_host_model_i (.clk(clk), .d_oe(d_oe), .d_out(d_out),
    .interface_select_0(interface_select_0), .interface_select_1(interface_select_1),
    .interface_select_2(interface_select_2), .cs_n(cs_n), .dc_sel(dc_sel),
    .rw_wr_n(rw_wr_n), .e_rd_n(e_rd_n), .d_in(d_in));
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic colset(input logic [7:0] v);
    @(posedge clk);
    col_value <= v;
    col_load <= 1'b1;
    @(posedge clk);
    col_load <= 1'b0;
    wt(3);
  endtask
  // The command decoder stalls at random so the buffer sees back pressure.
  always @(posedge clk) cmd_ready <= !stall && (($random(seed) & 1) != 0);
  always @(posedge clk) begin
    if (rst_n === 1'b1 && cmd_valid === 1'b1 && cmd_ready === 1'b1) begin
      if (exp_q.size() == 0) chk("cmd_extra", cmd_byte, 8'hxx);
      else chk("cmd_byte", cmd_byte, exp_q.pop_front());
    end
  end
  initial begin
    #200000;
    err_count++;
    print_verdict();
  end
  // --------------------------------
  // Scenarios
  // --------------------------------
  initial begin
    rst_n = 1'b0;
    stall = 1'b0;
    cmd_ready = 1'b0;
    col_load = 1'b0;
    col_value = 8'h00;
    page_sel = 3'h0;
    wt(4);
    rst_n <= 1'b1;
    wt(20);
    chk("column_q", column_q, 8'h00);
    for (int i = 0; i < 2; i++) begin
      dhi_host_model_i.mode(i ? 3'h6 : 3'h4);
      rb = 8'($random(seed)) & 8'h7f;
      exp_q.push_back(rb);
      dhi_host_model_i.pwr(1'b0, rb);
      dhi_host_model_i.pwr(1'b1, 8'($random(seed)));
      dhi_host_model_i.skip_cs = 1'b1;
      dhi_host_model_i.pwr(1'b1, 8'h5a);
      dhi_host_model_i.skip_cs = 1'b0;
      wt(10);
      chk("column_q", column_q, 8'(i + 1));
      dhi_host_model_i.prd(1'b0, rb);
      chk("status", rb, 8'h40);
    end
    d0 = 8'($random(seed));
    d1 = ~d0;
    cv = 8'($random(seed)) & 8'h7f;
    page_sel <= 3'($random(seed));
    colset(cv);
    dhi_host_model_i.pwr(1'b1, d0);
    dhi_host_model_i.pwr(1'b1, d1);
    // The same column on the next page must not alias the bytes just written.
    page_sel <= page_sel + 3'h1;
    colset(cv);
    dhi_host_model_i.pwr(1'b1, d0 ^ 8'h5a);
    page_sel <= page_sel - 3'h1;
    colset(cv);
    dhi_host_model_i.prd(1'b1, rb);
    dhi_host_model_i.prd(1'b1, rb);
    chk("ram_read", rb, d0);
    dhi_host_model_i.prd(1'b1, rb);
    chk("ram_read", rb, d1);
    stall <= 1'b1;
    dhi_host_model_i.mode(3'h4);
    for (int i = 0; i < 3; i++) begin
      rb = 8'h10 + 8'(i);
      if (i < 2) exp_q.push_back(rb);
      dhi_host_model_i.pwr(1'b0, rb);
    end
    dhi_host_model_i.prd(1'b0, rb);
    chk("status", rb, 8'hc0);
    stall <= 1'b0;
    exp_q.push_back(8'haf);
    dhi_host_model_i.pwr(1'b0, 8'haf);
    wt(DISP_ON_CYCLES + 40);
    chk("display_on", {7'h00, display_on_q}, 8'h01);
    exp_q.push_back(8'hae);
    dhi_host_model_i.pwr(1'b0, 8'hae);
    wt(20);
    chk("display_on", {7'h00, display_on_q}, 8'h00);
    dhi_host_model_i.mode(3'h0);
    colset(8'h00);
    dhi_host_model_i.spi(1'b0, 8'hff, 3);
    dhi_host_model_i.desel();
    rb = 8'($random(seed)) & 8'h7f;
    exp_q.push_back(rb);
    exp_q.push_back(8'he0);
    dhi_host_model_i.spi(1'b0, rb, 8);
    dhi_host_model_i.spi(1'b1, 8'h3c, 8);
    // The no-operation value is arbitrary for this block, which only forwards it.
    dhi_host_model_i.spi(1'b0, 8'he0, 8);
    dhi_host_model_i.desel();
    chk("column_q", column_q, 8'h01);
    dhi_host_model_i.mode(3'h2);
    colset(8'h00);
    rb = 8'($random(seed)) & 8'h7f;
    seq = '{8'h7a, 8'h80, rb, 8'h40, 8'h11, 8'h22, 8'h78, 8'h00, 8'h33};
    exp_q.push_back(rb);
    for (int i = 0; i < 9; i++) begin
      if (i == 0 || i == 6) dhi_host_model_i.i2c_start();
      dhi_host_model_i.i2c_byte(seq[i], ack);
      chk("i2c_ack", {7'h00, ack}, {7'h00, i > 5});
      if (i == 5 || i == 8) dhi_host_model_i.i2c_stop();
    end
    wt(20);
    chk("column_q", column_q, 8'h02);
    chk("pending", 8'(exp_q.size()), 8'h00);
    print_verdict();
  end
endmodule
bind dhi_top dhi_top_monitor #(.DISP_ON_CYCLES(DISP_ON_CYCLES)) dhi_top_monitor_i (.clk(clk),
  .rst_n(rst_n), .interface_select_0(interface_select_0), .interface_select_1(interface_select_1),
  .interface_select_2(interface_select_2), .cs_n(cs_n), .d_oe(d_oe), .cmd_valid(cmd_valid),
  .cmd_ready(cmd_ready), .cmd_byte(cmd_byte), .col_load(col_load), .column_q(column_q),
  .display_on_q(display_on_q));
`default_nettype wire
